// ===== mmbd_consts.vh
// Purpose: Shared constants of the memory map, boot capture and cache control block.
// Assumes: Byte addresses are 24 bits wide and memory words are 16 bits wide.
// Notes: Register offsets index 16-bit registers on the plain register port.
`ifndef MMBD_CONSTS_VH
`define MMBD_CONSTS_VH
// Address map.
`define MMBD_ROM_BASE 24'hff8000
`define MMBD_MMR_TOP 16'h00c0
`define MMBD_RG_REV 24'hffecae
`define MMBD_RG_BRT 24'hffecb0
`define MMBD_RG_SINE 24'hffed00
`define MMBD_RG_RSV 24'hffef00
`define MMBD_RG_VEC 24'hffff00
// Decode target bits; bits 3..0 are the four chip-enable spaces.
`define MMBD_T_RAM 6
`define MMBD_T_MMR 5
`define MMBD_T_ROM 4
// Requesting buses of the CPU channel.
`define MMBD_BUS_P 2'h0
`define MMBD_BUS_E 2'h3
// ROM access cycles.
`define MMBD_ROM_FIRST 3'h4
`define MMBD_ROM_NEXT 3'h2
// Boot codes that disable the ROM, then the synchroniser fill count.
`define MMBD_BOOT_NOROM_A 3'h0
`define MMBD_BOOT_NOROM_B 3'h4
`define MMBD_SYNC_FILL 2'h3
// Register offsets.
`define MMBD_REG_STAT3 4'h0
`define MMBD_REG_BOOT 4'h1
`define MMBD_REG_GOUT 4'h2
`define MMBD_REG_GDIR 4'h3
`define MMBD_REG_GIN 4'h4
// Status register 3 fields, then the valid bit of the boot register.
`define MMBD_ST_ROMDIS 0
`define MMBD_ST_ICEN 1
`define MMBD_ST_ICFRZ 2
`define MMBD_ST_ICFLUSH 3
`define MMBD_BOOT_VALID 15
// Cache address fields.
`define MMBD_IC_IDX_LSB 4
`define MMBD_IC_TAG_LSB 13
`endif

// ===== mmbd_cpu_bfm.sv
// Purpose: CPU bus master that issues one channel A request per go pulse.
// Assumes: The bench holds bus, address and data steady until idle returns.
// Notes: Reports cycles from the taken edge to the done edge in o_lat.
`timescale 1ns/100ps
module mmbd_cpu_bfm (
	// Clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// Bench side
	input wire i_go,
	output wire o_idle,
	output reg [7:0] o_lat,
	output reg o_err,
	output reg [15:0] o_rdata,
	// Block side
	output reg o_req,
	input wire i_done,
	input wire i_err,
	input wire [15:0] i_rdata
);
	reg wt_r;
	assign o_idle = !o_req && !wt_r;
	// Request stays one cycle since the block is idle whenever a new one starts.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_req <= 1'b0;
			wt_r <= 1'b0;
			o_lat <= 8'h00;
		end else if (o_req) begin
			o_req <= 1'b0;
			wt_r <= 1'b1;
			o_lat <= 8'h01;
		end else if (wt_r && i_done) begin
			wt_r <= 1'b0;
			o_err <= i_err;
			o_rdata <= i_rdata;
		end else if (wt_r) begin
			o_lat <= o_lat + 8'h01;
		end else if (i_go) begin
			o_req <= 1'b1;
		end
	end
endmodule

// ===== mmbd_dpram.v
// Purpose: Two-port RAM, each port may read or write in every cycle.
// Assumes: Read data appear one clock after the enabled access.
// Notes: When both ports write one word in a cycle, port B wins.
`timescale 1ns/100ps
module mmbd_dpram #(
	parameter DW = 16,
	parameter AW = 15
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_a_en,
	input wire i_a_we,
	input wire [AW-1:0] i_a_addr,
	input wire [DW-1:0] i_a_wdata,
	output reg [DW-1:0] o_a_rdata,
	input wire i_b_en,
	input wire i_b_we,
	input wire [AW-1:0] i_b_addr,
	input wire [DW-1:0] i_b_wdata,
	output reg [DW-1:0] o_b_rdata
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge i_clk) begin
		if (i_a_en && i_a_we)
			mem[i_a_addr] <= i_a_wdata;
		if (i_b_en && i_b_we)
			mem[i_b_addr] <= i_b_wdata;
	end

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_a_rdata <= {DW{1'b0}};
			o_b_rdata <= {DW{1'b0}};
		end else begin
			if (i_a_en)
				o_a_rdata <= mem[i_a_addr];
			if (i_b_en)
				o_b_rdata <= mem[i_b_addr];
		end
	end
endmodule

// ===== mmbd_icache.v
// Purpose: Tag store and replacement of the two-way instruction cache.
// Assumes: Line data live outside; a miss allocates the chosen line at once unless i_freeze is set.
// Notes: Flush walks all sets, one per cycle, ignoring lookups; reset starts one.
`timescale 1ns/100ps
`include "mmbd_consts.vh"
module mmbd_icache #(
	parameter IW = 9,
	parameter TW = 11
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_en,
	input wire i_freeze,
	input wire i_flush,
	input wire i_req,
	input wire [23:0] i_addr,
	output reg o_hit,
	output reg o_miss,
	output reg o_way,
	output reg o_busy
);
	localparam WW = 2*TW+3;
	reg lk_r;
	reg wr_vld_r;
	reg [IW-1:0] lk_idx_r;
	reg [IW-1:0] wr_idx_r;
	reg [IW-1:0] fl_cnt_r;
	reg [TW-1:0] lk_tag_r;
	reg [WW-1:0] wr_word_r;
	reg [WW-1:0] nw;
	wire [WW-1:0] rd_word;
	// A set written in the previous cycle is read stale, so it is forwarded.
	wire [WW-1:0] word = (wr_vld_r && wr_idx_r == lk_idx_r) ? wr_word_r : rd_word;
	wire h0 = word[TW] && word[TW-1:0] == lk_tag_r;
	wire h1 = word[2*TW+1] && word[2*TW:TW+1] == lk_tag_r;
	wire hit = h0 || h1;
	wire vict = !word[TW] ? 1'b0 : (!word[2*TW+1] ? 1'b1 : word[WW-1]); // R17
	wire way = hit ? h1 : vict;
	wire lk_en = i_req && i_en && !o_busy;
	wire wb_en = (lk_r && !i_freeze) || o_busy; // R18

	always @* begin
		nw = word;
		if (!hit && way)
			nw[2*TW+1:TW+1] = {1'b1, lk_tag_r}; // R16
		if (!hit && !way)
			nw[TW:0] = {1'b1, lk_tag_r};
		nw[WW-1] = ~way; // R17
	end

	mmbd_dpram #(.DW(WW), .AW(IW)) u_tags (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_a_en(lk_en),
		.i_a_we(1'b0),
		.i_a_addr(i_addr[`MMBD_IC_IDX_LSB+IW-1:`MMBD_IC_IDX_LSB]),
		.i_a_wdata({WW{1'b0}}),
		.o_a_rdata(rd_word),
		.i_b_en(wb_en),
		.i_b_we(wb_en),
		.i_b_addr(o_busy ? fl_cnt_r : lk_idx_r),
		.i_b_wdata(o_busy ? {WW{1'b0}} : nw),
		.o_b_rdata()
	);

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lk_r <= 1'b0;
			wr_vld_r <= 1'b0;
			lk_idx_r <= {IW{1'b0}};
			wr_idx_r <= {IW{1'b0}};
			fl_cnt_r <= {IW{1'b0}};
			lk_tag_r <= {TW{1'b0}};
			wr_word_r <= {WW{1'b0}};
			o_hit <= 1'b0;
			o_miss <= 1'b0;
			o_way <= 1'b0;
			o_busy <= 1'b1;
		end else begin
			lk_r <= lk_en;
			lk_idx_r <= i_addr[`MMBD_IC_IDX_LSB+IW-1:`MMBD_IC_IDX_LSB];
			lk_tag_r <= i_addr[`MMBD_IC_IDX_LSB+IW+TW-1:`MMBD_IC_IDX_LSB+IW];
			wr_vld_r <= wb_en;
			wr_idx_r <= o_busy ? fl_cnt_r : lk_idx_r;
			wr_word_r <= o_busy ? {WW{1'b0}} : nw;
			o_hit <= lk_r && hit;
			o_miss <= lk_r && !hit;
			if (lk_r)
				o_way <= way;
			if (o_busy) begin
				fl_cnt_r <= fl_cnt_r + 1'b1;
				if (fl_cnt_r == {IW{1'b1}})
					o_busy <= 1'b0;
			end else if (i_flush) begin
				o_busy <= 1'b1; // R18
				fl_cnt_r <= {IW{1'b0}};
			end
		end
	end
endmodule

// ===== mmbd_top.v
// Purpose: Memory map decode, ROM timing, boot-mode capture and cache control.
// Assumes: Channel A serves the CPU buses, channel B the DMA and host port.
// Notes: ROM, mapped registers and chip-enable spaces answer outside this block.
// How it works
// (R1) ROM decodes at FF8000h and above while the ROM-disable bit is 0.
// (R2) With ROM-disable set, that range decodes to external chip-enable space.
// (R3) Boot code 0 or 4 sets ROM-disable at reset; others clear it.
// (R4) Boot pins are sampled once per hardware reset only.
// (R5) Software reset leaves the ROM-disable bit untouched.
// (R6) Software may write the ROM-disable bit at any time; here boot capture overwrites earlier writes and wins over one in its own cycle.
// (R7) ROM answers reads from program, C and D buses only.
// (R8) ROM takes four cycles for the first word, two per following word.
// (R9) ROM regions: loader, revision, branch table, sine, reserved, vectors.
// (R10) Sine table region holds 256 Q15 entries covering one period.
// (R11) Bytes 000000h-00FFFFh decode to eight 8K-byte RAM blocks.
// (R12) RAM takes two accesses per cycle, any read/write mix.
// (R13) RAM reachable from program, data and DMA buses.
// (R14) Host port cannot reach the RAM while the device is in reset.
// (R15) First 192 bytes of block 0 are mapped registers, not storage.
// (R16) Cache is two-way, 512 sets, four 32-bit words per line, tagged.
// (R17) Cache miss replaces the least recently used way of the set.
// (R18) Status register bits enable, freeze and flush the cache.
// (R19) Boot pins are captured at the rising edge of reset; the code latches them a few clocks after it, once synchronised.
// (R20) After capture the boot pins act as general-purpose lines.
// (R21) Latched code selects one of eight boot processes.
// (R22) Other addresses decode to four 4M-byte chip-enable spaces.
`timescale 1ns/100ps
`include "mmbd_consts.vh"
module mmbd_top #(
	parameter RAM_AW = 15,
	parameter IC_IW = 9
) (
	// Clock and reset
	input wire I_MCLK,
	input wire I_RST_N,
	input wire I_SOFT_RST,
	// Boot-mode pins shared with general-purpose lines
	input wire [2:0] I_BOOT_MODE_PINS,
	output wire [2:0] O_GPIO_OUT,
	output wire [2:0] O_GPIO_OE_N,
	// Register port
	input wire [3:0] I_REG_ADDR,
	input wire [15:0] I_REG_WDATA,
	input wire I_REG_WR,
	input wire I_REG_RD,
	output wire [15:0] O_REG_RDATA,
	// CPU channel
	input wire I_A_REQ,
	input wire [1:0] I_A_BUS,
	input wire [23:0] I_A_ADDR,
	input wire I_A_WR,
	input wire [15:0] I_A_WDATA,
	output wire O_A_DONE,
	output wire O_A_ERR,
	output wire O_A_BUSY,
	output wire [6:0] O_A_TARGET,
	output wire [15:0] O_A_RDATA,
	// ROM macro side
	output wire [13:0] O_ROM_ADDR,
	output wire [5:0] O_ROM_REGION,
	output wire [7:0] O_SINE_IDX,
	// DMA and host channel
	input wire I_B_REQ,
	input wire I_B_HOST,
	input wire [23:0] I_B_ADDR,
	input wire I_B_WR,
	input wire [15:0] I_B_WDATA,
	output wire O_B_DONE,
	output wire O_B_ERR,
	output wire [15:0] O_B_RDATA,
	// Cache lookup result
	output wire O_IC_HIT,
	output wire O_IC_MISS,
	output wire O_IC_WAY,
	// Boot status
	output wire O_ROM_DIS,
	output wire O_BOOT_VALID,
	output wire [2:0] O_BOOT_MODE,
	output wire [7:0] O_BOOT_SEL
);
	localparam S_IDLE = 2'h1;
	localparam S_ROM = 2'h2;

	reg [2:0] pin_s1_r;
	reg [2:0] pin_s2_r;
	reg [2:0] pin_s3_r;
	reg [1:0] fill_cnt_r;
	reg boot_valid_r;
	reg [2:0] boot_mode_r;
	reg [7:0] boot_sel_r;
	reg [2:0] gpio_in_r;
	reg rom_dis_r;
	reg ic_en_r;
	reg ic_frz_r;
	reg ic_flush_r;
	reg [2:0] gpio_out_r;
	reg [2:0] gpio_dir_r;
	reg [2:0] gpio_oe_n_r;
	reg [15:0] rdata_r;
	reg [1:0] a_st_r;
	reg [2:0] a_wait_r;
	reg a_done_r;
	reg a_err_r;
	reg [6:0] a_tgt_r;
	reg [13:0] rom_addr_r;
	reg [5:0] rom_rg_r;
	reg [7:0] sine_r;
	reg last_rom_r;
	reg [23:0] last_addr_r;
	reg b_done_r;
	reg b_err_r;
	wire ic_busy;

	// Target decode: {RAM, mapped regs, ROM, chip-enable 3..0}.
	function [6:0] f_dec;
		input [23:0] a;
		input rdis;
		reg [6:0] t;
		begin
			t = 7'h00;
			if (a[23:16] == 8'h00) begin
				t[`MMBD_T_RAM] = 1'b1; // R11
				if (a[15:0] < `MMBD_MMR_TOP)
					t[`MMBD_T_MMR] = 1'b1; // R15
			end else if (!rdis && a >= `MMBD_ROM_BASE)
				t[`MMBD_T_ROM] = 1'b1; // R1
			else
				t[a[23:22]] = 1'b1; // R2 R22
			f_dec = t;
		end
	endfunction

	// ROM content region, one-hot from loader (bit 0) to vectors (bit 5).
	function [5:0] f_region;
		input [23:0] a;
		begin
			if (a >= `MMBD_RG_VEC)
				f_region = 6'h20;
			else if (a >= `MMBD_RG_RSV)
				f_region = 6'h10;
			else if (a >= `MMBD_RG_SINE)
				f_region = 6'h08;
			else if (a >= `MMBD_RG_BRT)
				f_region = 6'h04;
			else if (a >= `MMBD_RG_REV)
				f_region = 6'h02;
			else
				f_region = 6'h01;
		end
	endfunction

	// Boot pins arrive from outside the clock domain.
	always @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pin_s1_r <= 3'h0;
			pin_s2_r <= 3'h0;
			pin_s3_r <= 3'h0;
		end else begin
			pin_s1_r <= I_BOOT_MODE_PINS;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	wire pins_stable = (pin_s2_r == pin_s3_r);
	wire capture = !boot_valid_r && fill_cnt_r == `MMBD_SYNC_FILL && pins_stable;
	wire no_rom = (pin_s3_r == `MMBD_BOOT_NOROM_A) || (pin_s3_r == `MMBD_BOOT_NOROM_B);

	// The pins are caught once the synchroniser has refilled after the release
	// of reset, so the capture lags the reset edge by a few clocks.
	always @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			fill_cnt_r <= 2'h0;
			boot_valid_r <= 1'b0;
			boot_mode_r <= 3'h0;
			boot_sel_r <= 8'h00;
			gpio_in_r <= 3'h0;
		end else begin
			if (fill_cnt_r != `MMBD_SYNC_FILL)
				fill_cnt_r <= fill_cnt_r + 2'h1;
			if (capture) begin
				boot_valid_r <= 1'b1; // R4 R19
				boot_mode_r <= pin_s3_r; // R19
				boot_sel_r <= 8'h01 << pin_s3_r; // R21
			end
			if (pins_stable && boot_valid_r)
				gpio_in_r <= pin_s3_r; // R20
		end
	end

	wire wr_st = I_REG_WR && I_REG_ADDR == `MMBD_REG_STAT3;

	always @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rom_dis_r <= 1'b0;
			ic_en_r <= 1'b0;
			ic_frz_r <= 1'b0;
			ic_flush_r <= 1'b0;
			gpio_out_r <= 3'h0;
			gpio_dir_r <= 3'h0;
			gpio_oe_n_r <= 3'h7;
		end else begin
			ic_flush_r <= 1'b0;
			// Capture wins over a software write in the same cycle.
			if (capture)
				rom_dis_r <= no_rom; // R3
			else if (wr_st)
				rom_dis_r <= I_REG_WDATA[`MMBD_ST_ROMDIS]; // R6
			if (I_SOFT_RST) begin
				ic_en_r <= 1'b0; // R5
				ic_frz_r <= 1'b0;
				gpio_out_r <= 3'h0;
				gpio_dir_r <= 3'h0;
				gpio_oe_n_r <= 3'h7;
			end else begin
				if (wr_st) begin
					ic_en_r <= I_REG_WDATA[`MMBD_ST_ICEN]; // R18
					ic_frz_r <= I_REG_WDATA[`MMBD_ST_ICFRZ]; // R18
					ic_flush_r <= I_REG_WDATA[`MMBD_ST_ICFLUSH]; // R18
				end
				if (I_REG_WR && I_REG_ADDR == `MMBD_REG_GOUT)
					gpio_out_r <= I_REG_WDATA[2:0];
				if (I_REG_WR && I_REG_ADDR == `MMBD_REG_GDIR) begin
					gpio_dir_r <= I_REG_WDATA[2:0];
					gpio_oe_n_r <= ~I_REG_WDATA[2:0];
				end
			end
		end
	end

	always @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= 16'h0000;
			if (I_REG_RD) begin
				case (I_REG_ADDR)
				`MMBD_REG_STAT3: rdata_r <= {12'h000, ic_busy, ic_frz_r, ic_en_r, rom_dis_r};
				`MMBD_REG_BOOT: rdata_r <= {boot_valid_r, 12'h000, boot_mode_r};
				`MMBD_REG_GOUT: rdata_r <= {13'h0000, gpio_out_r};
				`MMBD_REG_GDIR: rdata_r <= {13'h0000, gpio_dir_r};
				`MMBD_REG_GIN: rdata_r <= {13'h0000, gpio_in_r};
				default: rdata_r <= 16'h0000;
				endcase
			end
		end
	end

	// CPU channel.
	wire [6:0] a_dec = f_dec(I_A_ADDR, rom_dis_r);
	wire a_take = I_A_REQ && a_st_r[0];
	wire a_rom_bad = a_dec[`MMBD_T_ROM] && (I_A_WR || I_A_BUS == `MMBD_BUS_E); // R7
	wire a_seq = last_rom_r && I_A_ADDR == last_addr_r + 24'h000002;
	wire [23:0] sine_off = I_A_ADDR - `MMBD_RG_SINE;
	wire [5:0] a_rg = f_region(I_A_ADDR);
	wire a_ram_en = a_take && a_dec[`MMBD_T_RAM]; // R13
	wire a_ram_we = a_ram_en && I_A_WR && !a_dec[`MMBD_T_MMR]; // R15
	wire ic_req = a_take && I_A_BUS == `MMBD_BUS_P && (|a_dec[3:0]) && !I_A_WR;

	always @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			a_st_r <= S_IDLE;
			a_wait_r <= 3'h0;
			a_done_r <= 1'b0;
			a_err_r <= 1'b0;
			a_tgt_r <= 7'h00;
			rom_addr_r <= 14'h0000;
			rom_rg_r <= 6'h00;
			sine_r <= 8'h00;
			last_rom_r <= 1'b0;
			last_addr_r <= 24'h000000;
		end else begin
			a_done_r <= 1'b0;
			a_err_r <= 1'b0;
			case (a_st_r)
			S_IDLE: begin
				if (I_A_REQ) begin
					a_tgt_r <= a_dec;
					if (a_dec[`MMBD_T_ROM] && !a_rom_bad) begin
						a_st_r <= S_ROM;
						a_wait_r <= (a_seq ? `MMBD_ROM_NEXT : `MMBD_ROM_FIRST) - 3'h1; // R8
						rom_addr_r <= I_A_ADDR[14:1];
						rom_rg_r <= a_rg; // R9
						sine_r <= a_rg[3] ? sine_off[8:1] : 8'h00; // R10
						last_rom_r <= 1'b1;
						last_addr_r <= I_A_ADDR;
					end else begin
						a_done_r <= 1'b1;
						a_err_r <= a_rom_bad; // R7
						last_rom_r <= 1'b0;
					end
				end
			end
			S_ROM: begin
				a_wait_r <= a_wait_r - 3'h1;
				if (a_wait_r == 3'h1) begin
					a_done_r <= 1'b1; // R8
					a_st_r <= S_IDLE;
				end
			end
			default: a_st_r <= S_IDLE;
			endcase
		end
	end

	// DMA and host channel, RAM only.
	wire [6:0] b_dec = f_dec(I_B_ADDR, rom_dis_r);
	wire b_bad = !b_dec[`MMBD_T_RAM] || (I_B_HOST && (!boot_valid_r || I_SOFT_RST)); // R14
	wire b_en = I_B_REQ && !b_bad; // R13
	wire b_we = b_en && I_B_WR && !b_dec[`MMBD_T_MMR]; // R15

	always @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			b_done_r <= 1'b0;
			b_err_r <= 1'b0;
		end else begin
			b_done_r <= I_B_REQ;
			b_err_r <= I_B_REQ && b_bad;
		end
	end

	// Both channels reach the RAM in the same cycle.
	mmbd_dpram #(.DW(16), .AW(RAM_AW)) u_ram (
		.i_clk(I_MCLK),
		.i_rst_n(I_RST_N),
		.i_a_en(a_ram_en),
		.i_a_we(a_ram_we),
		.i_a_addr(I_A_ADDR[RAM_AW:1]),
		.i_a_wdata(I_A_WDATA),
		.o_a_rdata(O_A_RDATA),
		.i_b_en(b_en),
		.i_b_we(b_we),
		.i_b_addr(I_B_ADDR[RAM_AW:1]),
		.i_b_wdata(I_B_WDATA),
		.o_b_rdata(O_B_RDATA)
	); // R12

	mmbd_icache #(.IW(IC_IW), .TW(24 - `MMBD_IC_IDX_LSB - IC_IW)) u_icache (
		.i_clk(I_MCLK),
		.i_rst_n(I_RST_N),
		.i_en(ic_en_r),
		.i_freeze(ic_frz_r),
		.i_flush(ic_flush_r),
		.i_req(ic_req),
		.i_addr(I_A_ADDR),
		.o_hit(O_IC_HIT),
		.o_miss(O_IC_MISS),
		.o_way(O_IC_WAY),
		.o_busy(ic_busy)
	); // R16

	assign O_GPIO_OUT = gpio_out_r;
	assign O_GPIO_OE_N = gpio_oe_n_r;
	assign O_REG_RDATA = rdata_r;
	assign O_A_DONE = a_done_r;
	assign O_A_ERR = a_err_r;
	assign O_A_BUSY = a_st_r[1];
	assign O_A_TARGET = a_tgt_r;
	assign O_ROM_ADDR = rom_addr_r;
	assign O_ROM_REGION = rom_rg_r;
	assign O_SINE_IDX = sine_r;
	assign O_B_DONE = b_done_r;
	assign O_B_ERR = b_err_r;
	assign O_ROM_DIS = rom_dis_r;
	assign O_BOOT_VALID = boot_valid_r;
	assign O_BOOT_MODE = boot_mode_r;
	assign O_BOOT_SEL = boot_sel_r;
endmodule

// ===== mmbd_top_sva.sv
// Purpose: Concurrent checks on decode, ROM timing and boot capture at the top ports.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes: Attached to the top module by the bind below the module.
`timescale 1ns/100ps
module mmbd_top_sva (
	// Clock, reset and register write strobe
	input wire I_MCLK,
	input wire I_RST_N,
	input wire I_SOFT_RST,
	input wire I_REG_WR,
	// CPU channel
	input wire I_A_REQ,
	input wire [1:0] I_A_BUS,
	input wire [23:0] I_A_ADDR,
	input wire I_A_WR,
	input wire O_A_DONE,
	input wire O_A_ERR,
	input wire O_A_BUSY,
	input wire [6:0] O_A_TARGET,
	// DMA and host channel
	input wire I_B_REQ,
	input wire I_B_HOST,
	input wire [23:0] I_B_ADDR,
	input wire O_B_DONE,
	input wire O_B_ERR,
	// Boot status
	input wire O_ROM_DIS,
	input wire O_BOOT_VALID,
	input wire [2:0] O_BOOT_MODE,
	input wire [7:0] O_BOOT_SEL
);
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (!I_RST_N);
	// A request is only taken while the ROM sequencer is idle.
	wire tk = I_A_REQ && !O_A_BUSY;
	wire rom = I_A_ADDR[23:15] == 9'h1ff;
	wire lo = I_A_ADDR[23:16] == 8'h00;
	// The mapped-register corner is left out, its target flags differ.
	wire ram = lo && I_A_ADDR[15:8] != 8'h00;
	wire romq = tk && rom && !O_ROM_DIS;
	wire rdok = !I_A_WR && I_A_BUS != 2'h3;
	wire nr = O_BOOT_MODE == 3'h0 || O_BOOT_MODE == 3'h4;

	a_ram_answer: assert property (tk && ram |=> O_A_DONE && !O_A_ERR && O_A_TARGET[6])
		else $error("RAM request not answered in the next cycle");
	a_rom_seq: assert property (romq && rdok |=> O_A_TARGET[4] && O_A_BUSY ##[1:3] O_A_DONE)
		else $error("ROM access timing wrong");
	a_rom_refuse: assert property (romq && !rdok |=> O_A_DONE && O_A_ERR)
		else $error("ROM write or bus E read not refused");
	a_rom_off: assert property (tk && rom && O_ROM_DIS |=> O_A_TARGET == 7'h08)
		else $error("Disabled ROM range not sent to CE3");
	a_ce_space: assert property (tk && !rom && !lo |=> O_A_TARGET == (7'h01 << $past(I_A_ADDR[23:22])))
		else $error("Chip-enable space decode wrong");
	a_boot_dis: assert property ($rose(O_BOOT_VALID) |-> O_ROM_DIS == nr)
		else $error("ROM disable bit wrong after capture");
	a_boot_hold: assert property (O_BOOT_VALID && $past(O_BOOT_VALID) |-> $stable(O_BOOT_MODE))
		else $error("Boot code changed after capture");
	a_soft_keep: assert property (I_SOFT_RST && O_BOOT_VALID && !I_REG_WR |=> $stable(O_ROM_DIS))
		else $error("Software reset changed ROM disable");
	a_host_block: assert property (I_B_REQ && I_B_HOST && !O_BOOT_VALID |=> O_B_DONE && O_B_ERR)
		else $error("Host access not refused before capture");
	a_dma_ram: assert property (I_B_REQ && !I_B_HOST && I_B_ADDR[23:16] == 8'h00 |=> O_B_DONE && !O_B_ERR)
		else $error("DMA access to RAM not answered");
	a_sel_code: assert property (O_BOOT_VALID |-> O_BOOT_SEL == (8'h01 << O_BOOT_MODE))
		else $error("Boot select not one-hot of the code");
endmodule

bind mmbd_top mmbd_top_sva u_sva (
	.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_SOFT_RST(I_SOFT_RST), .I_REG_WR(I_REG_WR),
	.I_A_REQ(I_A_REQ), .I_A_BUS(I_A_BUS), .I_A_ADDR(I_A_ADDR), .I_A_WR(I_A_WR),
	.O_A_DONE(O_A_DONE), .O_A_ERR(O_A_ERR), .O_A_BUSY(O_A_BUSY), .O_A_TARGET(O_A_TARGET),
	.I_B_REQ(I_B_REQ), .I_B_HOST(I_B_HOST), .I_B_ADDR(I_B_ADDR), .O_B_DONE(O_B_DONE),
	.O_B_ERR(O_B_ERR), .O_ROM_DIS(O_ROM_DIS), .O_BOOT_VALID(O_BOOT_VALID),
	.O_BOOT_MODE(O_BOOT_MODE), .O_BOOT_SEL(O_BOOT_SEL)
);

// ===== tb_memory_map_boot_decode.sv
// Purpose: Self-checking bench for boot capture, address decode, ROM timing and cache.
// Assumes: Design built with a short cache index to keep flushes brief.
// Notes: Each scenario is one task; a watchdog ends a hung run.
`timescale 1ns/100ps
module tb_memory_map_boot_decode;
	reg I_MCLK = 1'b0;
	reg I_RST_N = 1'b0;
	reg I_SOFT_RST = 1'b0;
	reg [2:0] I_BOOT_MODE_PINS = 3'h0;
	reg [3:0] I_REG_ADDR = 4'h0;
	reg [15:0] I_REG_WDATA = 16'h0000;
	reg I_REG_WR = 1'b0;
	reg I_REG_RD = 1'b0;
	reg [1:0] I_A_BUS = 2'h0;
	reg [23:0] I_A_ADDR = 24'h000000;
	reg I_A_WR = 1'b0;
	reg [15:0] I_A_WDATA = 16'h0000;
	reg I_B_REQ = 1'b0;
	reg I_B_HOST = 1'b0;
	reg [23:0] I_B_ADDR = 24'h000000;
	reg I_B_WR = 1'b0;
	reg [15:0] I_B_WDATA = 16'h0000;
	reg go = 1'b0;
	integer hit_n = 0;
	integer miss_n = 0;
	reg b_er;
	reg [15:0] b_rd;
	reg [23:0] tbl [0:5];
	integer n_fail = 0;
	integer samples_checked = 0;
	integer cyc = 0;
	wire I_A_REQ, O_A_DONE, O_A_ERR, O_A_BUSY, O_B_DONE, O_B_ERR, O_IC_HIT, O_IC_MISS;
	wire O_IC_WAY, O_ROM_DIS, O_BOOT_VALID, idle, a_err;
	wire [15:0] O_REG_RDATA, O_A_RDATA, O_B_RDATA, a_rdata;
	wire [6:0] O_A_TARGET;
	wire [13:0] O_ROM_ADDR;
	wire [5:0] O_ROM_REGION;
	wire [7:0] O_SINE_IDX, O_BOOT_SEL, lat;
	wire [2:0] O_BOOT_MODE, O_GPIO_OUT, O_GPIO_OE_N;

	mmbd_top #(.RAM_AW(15), .IC_IW(4)) uut (
		.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_SOFT_RST(I_SOFT_RST),
		.I_BOOT_MODE_PINS(I_BOOT_MODE_PINS), .O_GPIO_OUT(O_GPIO_OUT), .O_GPIO_OE_N(O_GPIO_OE_N),
		.I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR),
		.I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA), .I_A_REQ(I_A_REQ), .I_A_BUS(I_A_BUS),
		.I_A_ADDR(I_A_ADDR), .I_A_WR(I_A_WR), .I_A_WDATA(I_A_WDATA), .O_A_DONE(O_A_DONE),
		.O_A_ERR(O_A_ERR), .O_A_BUSY(O_A_BUSY), .O_A_TARGET(O_A_TARGET), .O_A_RDATA(O_A_RDATA),
		.O_ROM_ADDR(O_ROM_ADDR), .O_ROM_REGION(O_ROM_REGION), .O_SINE_IDX(O_SINE_IDX),
		.I_B_REQ(I_B_REQ), .I_B_HOST(I_B_HOST), .I_B_ADDR(I_B_ADDR), .I_B_WR(I_B_WR),
		.I_B_WDATA(I_B_WDATA), .O_B_DONE(O_B_DONE), .O_B_ERR(O_B_ERR), .O_B_RDATA(O_B_RDATA),
		.O_IC_HIT(O_IC_HIT), .O_IC_MISS(O_IC_MISS), .O_IC_WAY(O_IC_WAY), .O_ROM_DIS(O_ROM_DIS),
		.O_BOOT_VALID(O_BOOT_VALID), .O_BOOT_MODE(O_BOOT_MODE), .O_BOOT_SEL(O_BOOT_SEL)
	);
	mmbd_cpu_bfm cpu (
		.i_clk(I_MCLK), .i_rst_n(I_RST_N), .i_go(go), .o_idle(idle), .o_lat(lat),
		.o_err(a_err), .o_rdata(a_rdata), .o_req(I_A_REQ), .i_done(O_A_DONE),
		.i_err(O_A_ERR), .i_rdata(O_A_RDATA)
	);

	always #5 I_MCLK = ~I_MCLK;
	// Cache result pulses last one cycle, so they are counted here.
	always @(posedge I_MCLK) begin
		if (O_IC_HIT) begin
			hit_n <= hit_n + 1;
		end
		if (O_IC_MISS) begin
			miss_n <= miss_n + 1;
		end
	end
	always @(posedge I_MCLK) begin
		cyc = cyc + 1;
		if (cyc == 6000) begin
			n_fail = n_fail + 1;
			finish_test;
		end
	end

	task chk(input string nm, input [23:0] exp, input [23:0] got);
		begin
			samples_checked = samples_checked + 1;
			if (exp !== got) begin
				n_fail = n_fail + 1;
				$display("ERROR %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask

	task a_acc(input [1:0] b, input [23:0] a, input w, input [15:0] d);
		begin
			@(posedge I_MCLK);
			I_A_BUS <= b;
			I_A_ADDR <= a;
			I_A_WR <= w;
			I_A_WDATA <= d;
			go <= 1'b1;
			@(posedge I_MCLK);
			go <= 1'b0;
			#1;
			while (!idle) begin
				@(posedge I_MCLK);
				#1;
			end
		end
	endtask

	task b_acc(input h, input [23:0] a, input w, input [15:0] d);
		begin
			@(posedge I_MCLK);
			I_B_REQ <= 1'b1;
			I_B_HOST <= h;
			I_B_ADDR <= a;
			I_B_WR <= w;
			I_B_WDATA <= d;
			@(posedge I_MCLK);
			I_B_REQ <= 1'b0;
			#1;
			chk("b_done", 24'h1, O_B_DONE);
			b_er = O_B_ERR;
			b_rd = O_B_RDATA;
		end
	endtask

	task reg_io(input w, input [3:0] a, input [15:0] d);
		begin
			@(posedge I_MCLK);
			I_REG_WR <= w;
			I_REG_RD <= !w;
			I_REG_ADDR <= a;
			I_REG_WDATA <= d;
			@(posedge I_MCLK);
			I_REG_WR <= 1'b0;
			I_REG_RD <= 1'b0;
			#1;
		end
	endtask

	task t_boot;
		integer c;
		begin
			for (c = 0; c < 8; c = c + 1) begin
				@(posedge I_MCLK);
				I_BOOT_MODE_PINS <= c[2:0];
				I_RST_N <= 1'b0;
				repeat (10) @(posedge I_MCLK);
				I_RST_N <= 1'b1;
				b_acc(1'b1, 24'h002000, 1'b0, 16'h0000);
				chk("host_err", 24'h1, b_er);
				repeat (6) @(posedge I_MCLK);
				I_BOOT_MODE_PINS <= ~c[2:0];
				repeat (8) @(posedge I_MCLK);
				#1;
				chk("valid", 24'h1, O_BOOT_VALID);
				chk("rom_dis", (c == 0 || c == 4), O_ROM_DIS);
				chk("mode", c, O_BOOT_MODE);
				chk("sel", 8'h01 << c, O_BOOT_SEL);
			end
			$display("test boot done");
		end
	endtask

	task t_ram;
		begin
			a_acc(2'h3, 24'h00fffe, 1'b1, 16'h5a3c);
			b_acc(1'b0, 24'h00fffe, 1'b0, 16'h0000);
			chk("dma_rd", 16'h5a3c, b_rd);
			b_acc(1'b1, 24'h002006, 1'b1, 16'hc3a5);
			chk("host_ok", 24'h0, b_er);
			a_acc(2'h1, 24'h002006, 1'b0, 16'h0000);
			chk("a_rd", 16'hc3a5, a_rdata);
			chk("a_tgt", 7'h40, O_A_TARGET);
			b_acc(1'b0, 24'h0000c0, 1'b1, 16'h1111);
			a_acc(2'h3, 24'h0000be, 1'b1, 16'h2222);
			chk("mmr_tgt", 7'h60, O_A_TARGET);
			a_acc(2'h2, 24'h0000c0, 1'b0, 16'h0000);
			chk("mmr_edge", 16'h1111, a_rdata);
			b_acc(1'b0, 24'h100000, 1'b0, 16'h0000);
			chk("dma_far", 24'h1, b_er);
			$display("test ram done");
		end
	endtask

	task t_rom;
		integer i;
		begin
			a_acc(2'h0, 24'hff8000, 1'b0, 16'h0000);
			chk("lat_first", 24'h4, lat);
			chk("rom_tgt", 7'h10, O_A_TARGET);
			a_acc(2'h1, 24'hff8002, 1'b0, 16'h0000);
			chk("lat_next", 24'h2, lat);
			for (i = 0; i < 6; i = i + 1) begin
				a_acc(2'h2, tbl[i], 1'b0, 16'h0000);
				chk("region", 6'h01 << i, O_ROM_REGION);
				chk("rom_addr", tbl[i][14:1], O_ROM_ADDR);
			end
			a_acc(2'h2, 24'hffed1e, 1'b0, 16'h0000);
			chk("sine_idx", 8'h0f, O_SINE_IDX);
			a_acc(2'h3, 24'hff8000, 1'b0, 16'h0000);
			chk("bus_e", 24'h1, a_err);
			a_acc(2'h0, 24'hff8000, 1'b1, 16'h0000);
			chk("rom_wr", 24'h1, a_err);
			$display("test rom done");
		end
	endtask

	task t_rdis;
		begin
			reg_io(1'b1, 4'h0, 16'h0001);
			chk("dis_set", 24'h1, O_ROM_DIS);
			a_acc(2'h0, 24'hff8000, 1'b0, 16'h0000);
			chk("ce3", 7'h08, O_A_TARGET);
			chk("lat_ce", 24'h1, lat);
			@(posedge I_MCLK);
			I_SOFT_RST <= 1'b1;
			repeat (3) @(posedge I_MCLK);
			I_SOFT_RST <= 1'b0;
			#1;
			chk("soft", 24'h1, O_ROM_DIS);
			reg_io(1'b0, 4'h0, 16'h0000);
			chk("stat3", 24'h1, O_REG_RDATA[0]);
			reg_io(1'b1, 4'h0, 16'h0000);
			chk("dis_clr", 24'h0, O_ROM_DIS);
			a_acc(2'h0, 24'h400000, 1'b0, 16'h0000);
			chk("ce1", 7'h02, O_A_TARGET);
			reg_io(1'b1, 4'h3, 16'h0005);
			chk("oe_n", 3'h2, O_GPIO_OE_N);
			reg_io(1'b1, 4'h2, 16'h0003);
			chk("gout", 3'h3, O_GPIO_OUT);
			reg_io(1'b0, 4'h1, 16'h0000);
			chk("boot_reg", 16'h8007, O_REG_RDATA);
			$display("test rom disable done");
		end
	endtask

	task ic(input [23:0] a, input [1:0] e, input w);
		integer h;
		integer m;
		begin
			h = hit_n;
			m = miss_n;
			a_acc(2'h0, a, 1'b0, 16'h0000);
			repeat (3) @(posedge I_MCLK);
			#1;
			chk("ic_res", e, {hit_n - h == 1, miss_n - m == 1});
			chk("ic_way", w, O_IC_WAY);
		end
	endtask

	task t_cache;
		begin
			reg_io(1'b1, 4'h0, 16'h0002);
			ic(24'h010000, 2'b01, 1'b0);
			ic(24'h010000, 2'b10, 1'b0);
			ic(24'h012000, 2'b01, 1'b1);
			ic(24'h010000, 2'b10, 1'b0);
			ic(24'h014000, 2'b01, 1'b1);
			reg_io(1'b1, 4'h0, 16'h0006);
			ic(24'h012000, 2'b01, 1'b0);
			ic(24'h012000, 2'b01, 1'b0);
			reg_io(1'b1, 4'h0, 16'h000a);
			repeat (20) @(posedge I_MCLK);
			ic(24'h010000, 2'b01, 1'b0);
			reg_io(1'b1, 4'h0, 16'h0000);
			ic(24'h010000, 2'b00, 1'b0);
			$display("test cache done");
		end
	endtask

	task finish_test;
		begin
			$display("checks %0d mismatches %0d", samples_checked, n_fail);
			if (n_fail == 0 && samples_checked > 0) begin
				$display("Regression OK");
			end else begin
				$display("Regression broken");
			end
			$finish;
		end
	endtask

	initial begin
		tbl[0] = 24'hff8000;
		tbl[1] = 24'hffecae;
		tbl[2] = 24'hffecb0;
		tbl[3] = 24'hffed00;
		tbl[4] = 24'hffef00;
		tbl[5] = 24'hffff00;
		t_boot;
		t_ram;
		t_rom;
		t_rdis;
		t_cache;
		finish_test;
	end
endmodule
